/* File: src/omt_mode_ctrl.sv */
// Contract
// [RULE1] Finished tuning stores PID values and clears the execute setting.
// [RULE2] Interrupted tuning keeps the setting and restarts when conditions return.
// [RULE3] Each computed PID term is scaled by its factor, 0.01 to 10.00.
// [RULE4] Open Auto/Manual contact holds Manual and blocks key changes.
// [RULE5] Closed contact requests Auto, open contact requests Manual.
// [RULE6] Contact change applies after 200 ms plus one sampling cycle.
// [RULE7] Auto only if key and contact both ask Auto; lamp shows Manual.
// [RULE8] Bumpless Auto-to-Manual loads the last Auto output.
// [RULE9] Manual-to-Auto starts control from the Manual output.
// [RULE10] Handoff select chooses bumpless carry-over or stored manual output.
// [RULE11] Direct key in Auto/Manual use toggles that request.
// [RULE12] Direct key in Remote/Local use toggles that request.
// [RULE13] Manual lamp dark in STOP.
// [RULE14] Remote lamp dark in STOP.
// [RULE15] Manual valve without feedback: outputs follow keys, output value hidden.
// [RULE16] Manual valve with feedback: keys adjust target position.
// [RULE17] Closed contact requests Remote, open requests Local.
// [RULE18] Remote only if key and contact both ask Remote; lamp shows it.
// [RULE19] Key/communication and contact requests kept apart; latest command wins.
`timescale 1ns/10ps
`default_nettype none
module omt_mode_ctrl
    import omt_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    // Configuration
    input  wire omt_dkey_e         dkey_type_in,
    input  wire omt_di_e           di_assign_in,
    input  wire logic              handoff_bumpless_in,
    input  wire logic [CNT_W-1:0]  sample_cyc_in,
    input  wire logic              position_ctrl_in,
    input  wire logic              feedback_present_in,
    input  wire logic              run_in,
    // Operator and host
    input  wire omt_cmd_s          key_cmd_in,
    input  wire omt_cmd_s          comm_cmd_in,
    input  wire logic              direct_key_in,
    input  wire logic              inc_key_in,
    input  wire logic              dec_key_in,
    input  wire logic              contact_input_in,
    // Control loop
    input  wire logic [MV_W-1:0]   pid_output_in,
    // Tuning
    input  wire omt_tune_e         tune_setting_in,
    input  wire logic              tune_done_in,
    input  wire omt_pid_s          tune_result_in,
    input  wire omt_fact_s         tune_fact_in,
    // Mode results
    output logic                   auto_out,
    output logic                   remote_out,
    output logic                   hand_mode_lamp_out,
    output logic                   far_setpoint_lamp_out,
    output logic                   pid_preload_out,
    // Outputs
    output logic [MV_W-1:0]        manipulated_output_out,
    output logic                   mv_display_out,
    output logic                   open_side_output_out,
    output logic                   close_side_output_out,
    // Tuning results
    output omt_tune_e              tune_setting_out,
    output logic                   tune_setting_wr_out,
    output omt_pid_s               pid_values_out,
    output logic                   pid_values_wr_out
);
    logic             key_auto_r;
    logic             key_remote_r;
    logic             di_closed;
    logic             dk_s1_r;
    logic             dk_s2_r;
    logic             dk_prev_r;
    logic             dk_press;
    logic             inc_s1_r;
    logic             inc_s2_r;
    logic             dec_s1_r;
    logic             dec_s2_r;
    logic             di_auto;
    logic             di_remote;
    logic             auto_nxt;
    logic             remote_nxt;
    logic             prev_auto_r;
    logic [MV_W-1:0]  stored_man_r;

    // Scale a term by a hundredths factor
    function automatic logic [PID_W-1:0] omt_scale(input logic [PID_W-1:0] v,
                                                   input logic [FACT_W-1:0] f);
        logic [PID_W+FACT_W-1:0] prod;
        logic [PID_W+FACT_W-1:0] quo;
        prod = v * omt_clamp(f);
        quo  = prod / (PID_W+FACT_W)'(FACT_UNIT);
        if (quo > (PID_W+FACT_W)'({PID_W{1'b1}})) begin
            return {PID_W{1'b1}};
        end
        return quo[PID_W-1:0];
    endfunction : omt_scale

    // [RULE6] settle contact
    omt_contact_filter omt_contact_filter_i (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .contact_in    (contact_input_in),
        .sample_cyc_in (sample_cyc_in),
        .closed_out    (di_closed)
    );

    // Key pins are asynchronous to the clock
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dk_s1_r   <= 1'b0;
            dk_s2_r   <= 1'b0;
            dk_prev_r <= 1'b0;
            inc_s1_r  <= 1'b0;
            inc_s2_r  <= 1'b0;
            dec_s1_r  <= 1'b0;
            dec_s2_r  <= 1'b0;
        end else begin
            dk_s1_r   <= direct_key_in;
            dk_s2_r   <= dk_s1_r;
            dk_prev_r <= dk_s2_r;
            inc_s1_r  <= inc_key_in;
            inc_s2_r  <= inc_s1_r;
            dec_s1_r  <= dec_key_in;
            dec_s2_r  <= dec_s1_r;
        end
    end

    assign dk_press = dk_s2_r & ~dk_prev_r;

    // [RULE5] contact asks Auto when closed
    // [RULE17] contact asks Remote when closed
    assign di_auto   = (di_assign_in == OMT_DI_AM) ? di_closed : 1'b1;
    assign di_remote = (di_assign_in == OMT_DI_RL) ? di_closed : 1'b1;

    // [RULE19] key request register
    // [RULE4] key locked while contact open
    // [RULE11] direct key toggles
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            key_auto_r <= 1'b1;
        end else if (!di_auto) begin
            key_auto_r <= key_auto_r;
        end else if (comm_cmd_in.set_auto || comm_cmd_in.set_manual) begin
            key_auto_r <= comm_cmd_in.set_auto;
        end else if (key_cmd_in.set_auto || key_cmd_in.set_manual) begin
            key_auto_r <= key_cmd_in.set_auto;
        end else if (dk_press && dkey_type_in == OMT_DKEY_AM) begin
            key_auto_r <= ~key_auto_r;
        end
    end

    // [RULE19] remote request register
    // [RULE12] direct key toggles
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            key_remote_r <= 1'b0;
        end else if (comm_cmd_in.set_remote || comm_cmd_in.set_local) begin
            key_remote_r <= comm_cmd_in.set_remote;
        end else if (key_cmd_in.set_remote || key_cmd_in.set_local) begin
            key_remote_r <= key_cmd_in.set_remote;
        end else if (dk_press && dkey_type_in == OMT_DKEY_RL) begin
            key_remote_r <= ~key_remote_r;
        end
    end

    // [RULE7] both must ask Auto
    assign auto_nxt   = key_auto_r & di_auto;
    // [RULE18] both must ask Remote
    assign remote_nxt = key_remote_r & di_remote;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            auto_out              <= 1'b1;
            remote_out            <= 1'b0;
            prev_auto_r           <= 1'b1;
            hand_mode_lamp_out    <= 1'b0;
            far_setpoint_lamp_out <= 1'b0;
        end else begin
            auto_out              <= auto_nxt;
            remote_out            <= remote_nxt;
            prev_auto_r           <= auto_out;
            // [RULE13] Manual lamp dark in STOP
            hand_mode_lamp_out    <= run_in & ~auto_nxt;
            // [RULE14] Remote lamp dark in STOP
            far_setpoint_lamp_out <= run_in & remote_nxt;
        end
    end

    // Output handoff and manual adjustment
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            manipulated_output_out <= MV_RST;
            stored_man_r           <= MV_RST;
            pid_preload_out        <= 1'b0;
        end else begin
            pid_preload_out <= 1'b0;
            if (auto_out) begin
                if (!prev_auto_r) begin
                    // [RULE9] preload PID from Manual output
                    pid_preload_out <= 1'b1;
                end else begin
                    manipulated_output_out <= pid_output_in;
                end
            end else if (prev_auto_r) begin
                // [RULE10] pick handoff source
                // [RULE8] carry last Auto output
                manipulated_output_out <= handoff_bumpless_in ? manipulated_output_out
                                                              : stored_man_r;
            end else if (!position_ctrl_in || feedback_present_in) begin
                // [RULE16] keys move the target
                if (inc_s2_r && manipulated_output_out != {MV_W{1'b1}}) begin
                    manipulated_output_out <= manipulated_output_out + MV_STEP;
                    stored_man_r           <= manipulated_output_out + MV_STEP;
                end else if (dec_s2_r && manipulated_output_out != MV_RST) begin
                    manipulated_output_out <= manipulated_output_out - MV_STEP;
                    stored_man_r           <= manipulated_output_out - MV_STEP;
                end else begin
                    stored_man_r <= manipulated_output_out;
                end
            end
        end
    end

    // [RULE15] direct valve drive, value hidden
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            open_side_output_out  <= 1'b0;
            close_side_output_out <= 1'b0;
            mv_display_out        <= 1'b1;
        end else if (!auto_out && position_ctrl_in && !feedback_present_in) begin
            open_side_output_out  <= inc_s2_r & ~dec_s2_r;
            close_side_output_out <= dec_s2_r & ~inc_s2_r;
            mv_display_out        <= 1'b0;
        end else begin
            open_side_output_out  <= 1'b0;
            close_side_output_out <= 1'b0;
            mv_display_out        <= 1'b1;
        end
    end

    // Tuning completion; an interrupted run never pulses done
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pid_values_out      <= '0;
            pid_values_wr_out   <= 1'b0;
            tune_setting_out    <= OMT_TUNE_OFF;
            tune_setting_wr_out <= 1'b0;
        end else begin
            pid_values_wr_out   <= 1'b0;
            tune_setting_wr_out <= 1'b0;
            // [RULE2] no done keeps setting
            if (tune_done_in && tune_setting_in != OMT_TUNE_OFF) begin
                // [RULE3] scale each term
                pid_values_out.p_band <= omt_scale(tune_result_in.p_band,
                                                   tune_fact_in.p_fact);
                pid_values_out.i_time <= omt_scale(tune_result_in.i_time,
                                                   tune_fact_in.i_fact);
                pid_values_out.d_time <= omt_scale(tune_result_in.d_time,
                                                   tune_fact_in.d_fact);
                pid_values_wr_out     <= 1'b1;
                // [RULE1] clear the execute setting
                tune_setting_out      <= OMT_TUNE_OFF;
                tune_setting_wr_out   <= 1'b1;
            end
        end
    end
endmodule : omt_mode_ctrl
`default_nettype wire

/* File: common/omt_pkg.sv */
package omt_pkg;

    // Clock rate and contact settle timing
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned SETTLE_MS       = 200;
    localparam int unsigned SAMPLE_MS_DFLT  = 100;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned SETTLE_CYC      = SETTLE_MS * CYC_PER_MS;
    localparam int unsigned SAMPLE_CYC_DFLT = SAMPLE_MS_DFLT * CYC_PER_MS;
    localparam int unsigned CNT_W           = 24;

    // Output and factor widths
    localparam int unsigned MV_W      = 16;
    localparam int unsigned PID_W     = 16;
    localparam int unsigned FACT_W    = 10;
    // Factor fixed point: hundredths, 1 .. 1000
    localparam logic [FACT_W-1:0] FACT_MIN  = 10'h001;
    localparam logic [FACT_W-1:0] FACT_MAX  = 10'h3e8;
    localparam logic [FACT_W-1:0] FACT_UNIT = 10'h064;
    localparam logic [MV_W-1:0]   MV_RST    = 16'h0000;
    localparam logic [MV_W-1:0]   MV_STEP   = 16'h0001;

    // Direct key function
    typedef enum logic [1:0] {
        OMT_DKEY_NONE = 2'b00,
        OMT_DKEY_AM   = 2'b01,
        OMT_DKEY_RL   = 2'b10
    } omt_dkey_e;

    // Contact input assignment
    typedef enum logic [1:0] {
        OMT_DI_NONE = 2'b00,
        OMT_DI_AM   = 2'b01,
        OMT_DI_RL   = 2'b10
    } omt_di_e;

    // Tuning execute setting
    typedef enum logic [1:0] {
        OMT_TUNE_OFF    = 2'b00,
        OMT_TUNE_ONCE   = 2'b01,
        OMT_TUNE_ALWAYS = 2'b10
    } omt_tune_e;

    // Key or communication command
    typedef struct packed {
        logic set_auto;
        logic set_manual;
        logic set_remote;
        logic set_local;
    } omt_cmd_s;

    // Computed PID triple
    typedef struct packed {
        logic [PID_W-1:0] p_band;
        logic [PID_W-1:0] i_time;
        logic [PID_W-1:0] d_time;
    } omt_pid_s;

    // Adjusting factors
    typedef struct packed {
        logic [FACT_W-1:0] p_fact;
        logic [FACT_W-1:0] i_fact;
        logic [FACT_W-1:0] d_fact;
    } omt_fact_s;

    // Clamp a factor to its legal span
    function automatic logic [FACT_W-1:0] omt_clamp(input logic [FACT_W-1:0] f);
        if (f < FACT_MIN) begin
            return FACT_MIN;
        end
        if (f > FACT_MAX) begin
            return FACT_MAX;
        end
        return f;
    endfunction : omt_clamp

endpackage : omt_pkg

/* File: src/omt_contact_filter.sv */
`timescale 1ns/10ps
`default_nettype none
module omt_contact_filter
    import omt_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    // Contact pin and sampling period
    input  wire logic             contact_in,
    input  wire logic [CNT_W-1:0] sample_cyc_in,
    // Settled contact level
    output logic                  closed_out
);
    logic             sync1_r;
    logic             sync2_r;
    logic             seen_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] total;

    assign total = CNT_W'(SETTLE_CYC) + sample_cyc_in;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= contact_in;
            sync2_r <= sync1_r;
        end
    end

    // [RULE6] delay then apply
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            seen_r     <= 1'b0;
            cnt_r      <= '0;
            closed_out <= 1'b0;
        end else if (sync2_r != seen_r) begin
            // Any further change restarts the wait
            seen_r <= sync2_r;
            cnt_r  <= '0;
        end else if (seen_r != closed_out) begin
            if (cnt_r >= total - CNT_W'(1)) begin
                closed_out <= seen_r;
                cnt_r      <= '0;
            end else begin
                cnt_r <= cnt_r + CNT_W'(1);
            end
        end
    end
endmodule : omt_contact_filter
`default_nettype wire

/* File: verification/omt_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module omt_checker
    import omt_pkg::*;
(
    // Clock and reset
    input  wire logic            clk_in,
    input  wire logic            sys_rst_in,
    // Watched inputs
    input  wire omt_di_e         di_assign_in,
    input  wire logic            handoff_bumpless_in,
    input  wire logic            position_ctrl_in,
    input  wire logic            feedback_present_in,
    input  wire logic            run_in,
    input  wire omt_cmd_s        comm_cmd_in,
    input  wire omt_tune_e       tune_setting_in,
    input  wire logic            tune_done_in,
    // Watched outputs
    input  wire logic            auto_out,
    input  wire logic            remote_out,
    input  wire logic            hand_mode_lamp_out,
    input  wire logic            far_setpoint_lamp_out,
    input  wire logic            pid_preload_out,
    input  wire logic [MV_W-1:0] manipulated_output_out,
    input  wire logic            mv_display_out,
    input  wire logic            open_side_output_out,
    input  wire logic            close_side_output_out,
    input  wire omt_tune_e       tune_setting_out,
    input  wire logic            tune_setting_wr_out,
    input  wire logic            pid_values_wr_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_tune_take;
        tune_done_in && (tune_setting_in != OMT_TUNE_OFF);
    endsequence
    sequence s_tune_ans;
        tune_setting_wr_out && pid_values_wr_out && (tune_setting_out == OMT_TUNE_OFF);
    endsequence

    a_tune_clear: assert property (s_tune_take |=> s_tune_ans)
        else $error("tuning end did not clear the setting");
    a_tune_quiet: assert property (!tune_done_in |=> !tune_setting_wr_out && !pid_values_wr_out)
        else $error("setting written without tuning end");
    a_manual_cmd: assert property (comm_cmd_in.set_manual && !comm_cmd_in.set_auto
        && di_assign_in == OMT_DI_NONE |-> ##2 !auto_out)
        else $error("manual command not applied");
    a_resume_pid: assert property ($rose(auto_out) |-> ##[0:1] pid_preload_out)
        else $error("no preload on return to auto");
    a_bumpless_mv: assert property ($fell(auto_out) && handoff_bumpless_in
        |=> $stable(manipulated_output_out))
        else $error("output jumped on bumpless handoff");
    a_hand_lamp: assert property (hand_mode_lamp_out == ($past(run_in) && !auto_out))
        else $error("manual lamp wrong");
    a_far_lamp: assert property (far_setpoint_lamp_out == ($past(run_in) && remote_out))
        else $error("remote lamp wrong");
    a_hide_mv: assert property ((position_ctrl_in && !feedback_present_in && !auto_out)[*3]
        |-> !mv_display_out)
        else $error("output value shown without feedback");
    a_valve_excl: assert property (!(open_side_output_out && close_side_output_out))
        else $error("both valve outputs on");
endmodule : omt_checker
`default_nettype wire

/* File: verification/omt_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module omt_host_model
    import omt_pkg::*;
(
    // Clock
    input  wire logic     clk_in,
    // Requests from the bench
    input  wire omt_cmd_s cmd_in,
    input  wire logic     send_in,
    input  wire logic     close_in,
    // Far-side lines
    output omt_cmd_s      comm_cmd_out,
    output logic          contact_out
);
    initial comm_cmd_out = '0;
    initial contact_out = 1'b0;
    // Link word follows send_in every cycle, so a held request is repeated each cycle
    always @(posedge clk_in) begin
        comm_cmd_out <= send_in ? cmd_in : '0;
        contact_out  <= close_in;
    end
endmodule : omt_host_model
`default_nettype wire

/* File: verification/omt_mode_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module omt_mode_ctrl_tb;
    import omt_pkg::*;
    localparam omt_cmd_s C_AUTO = 4'h8;
    localparam omt_cmd_s C_MAN  = 4'h4;
    logic              clk_in = 1'b0;
    logic              sys_rst_in = 1'b1;
    omt_dkey_e         dkey_type_in = OMT_DKEY_NONE;
    omt_di_e           di_assign_in = OMT_DI_NONE;
    logic              handoff_bumpless_in = 1'b1;
    logic [CNT_W-1:0]  sample_cyc_in = 24'h000010;
    logic              position_ctrl_in = 1'b0;
    logic              feedback_present_in = 1'b0;
    logic              run_in = 1'b1;
    omt_cmd_s          key_cmd_in = '0;
    logic              direct_key_in = 1'b0;
    logic              inc_key_in = 1'b0;
    logic              dec_key_in = 1'b0;
    logic [MV_W-1:0]   pid_output_in = 16'h0000;
    omt_tune_e         tune_setting_in = OMT_TUNE_OFF;
    logic              tune_done_in = 1'b0;
    omt_pid_s          tune_result_in = '0;
    omt_fact_s         tune_fact_in = '0;
    omt_cmd_s          comm_cmd_in, host_cmd = '0;
    logic              contact_input_in, host_send = 1'b0, host_close = 1'b0;
    logic              auto_out, remote_out, hand_mode_lamp_out, far_setpoint_lamp_out;
    logic              pid_preload_out, mv_display_out, open_side_output_out;
    logic              close_side_output_out, tune_setting_wr_out, pid_values_wr_out;
    logic [MV_W-1:0]   manipulated_output_out, held;
    omt_tune_e         tune_setting_out;
    omt_pid_s          pid_values_out;
    int                mismatches = 0, comparisons = 0, cycles = 0;
    logic              exp_auto = 1'b1, exp_rem = 1'b0;

    omt_mode_ctrl omt_mode_ctrl_i (.*);
    omt_host_model omt_host_model_i (
        .clk_in       (clk_in),
        .cmd_in       (host_cmd),
        .send_in      (host_send),
        .close_in     (host_close),
        .comm_cmd_out (comm_cmd_in),
        .contact_out  (contact_input_in)
    );

    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic press(ref logic k, input int n);
        k = 1'b1;
        tick(n);
        k = 1'b0;
        tick(4);
    endtask : press
    task automatic check_modes();
        check("auto_out", auto_out, exp_auto);
        check("remote_out", remote_out, exp_rem);
        check("hand_lamp", hand_mode_lamp_out, run_in & ~exp_auto);
        check("far_lamp", far_setpoint_lamp_out, run_in & exp_rem);
    endtask : check_modes
    task automatic send(input omt_cmd_s c, input logic via_host);
        if (via_host) begin
            host_cmd = c;
            host_send = 1'b1;
        end else begin
            key_cmd_in = c;
        end
        tick(1);
        host_send = 1'b0;
        key_cmd_in = '0;
        tick(4);
        if (c.set_auto || c.set_manual) begin
            exp_auto = c.set_auto;
        end
        if (c.set_remote || c.set_local) begin
            exp_rem = c.set_remote;
        end
        check_modes();
    endtask : send
    function automatic logic [PID_W-1:0] scaled(input logic [PID_W-1:0] v,
                                                 input logic [FACT_W-1:0] f);
        logic [31:0] p;
        p = (32'(v) * 32'(f)) / 32'h64;
        return (p > 32'h0000ffff) ? 16'hffff : p[PID_W-1:0];
    endfunction : scaled

    initial begin
        void'($urandom(72));
        tick(2);
        sys_rst_in = 1'b0;
        check_modes();
        check("tune_rst", tune_setting_out, OMT_TUNE_OFF);
        tick(1);
        repeat (40) begin
            run_in = 1'($urandom);
            pid_output_in = 16'($urandom);
            send(omt_cmd_s'(4'h1 << $urandom_range(3)), 1'($urandom));
        end
        // Output handoff in both directions
        run_in = 1'b1;
        pid_output_in = 16'h1200 + 16'($urandom_range(255));
        held = pid_output_in;
        send(C_AUTO, 1'b0);
        check("mv_track", manipulated_output_out, held);
        send(C_MAN, 1'b1);
        pid_output_in = 16'h0100;
        press(inc_key_in, 5);
        held = held + 16'h0005;
        check("mv_bumpless", manipulated_output_out, held);
        send(C_AUTO, 1'b0);
        check("mv_resume", manipulated_output_out, 16'h0100);
        handoff_bumpless_in = 1'b0;
        send(C_MAN, 1'b0);
        check("mv_stored", manipulated_output_out, held);
        // Valve driven straight from the keys
        position_ctrl_in = 1'b1;
        inc_key_in = 1'b1;
        tick(4);
        check("open_on", open_side_output_out, 1'b1);
        check("mv_hidden", mv_display_out, 1'b0);
        inc_key_in = 1'b0;
        dec_key_in = 1'b1;
        tick(4);
        check("open_off", open_side_output_out, 1'b0);
        check("close_on", close_side_output_out, 1'b1);
        dec_key_in = 1'b0;
        tick(3);
        feedback_present_in = 1'b1;
        press(dec_key_in, 3);
        check("valve_target", manipulated_output_out, held - 16'h0003);
        position_ctrl_in = 1'b0;
        feedback_present_in = 1'b0;
        for (int t = 1; t < 3; t++) begin
            dkey_type_in = omt_dkey_e'(t);
            repeat (2) begin
                press(direct_key_in, 3);
                tick(2);
                exp_auto = (t == 1) ? ~exp_auto : exp_auto;
                exp_rem = (t == 2) ? ~exp_rem : exp_rem;
                check_modes();
            end
        end
        dkey_type_in = OMT_DKEY_NONE;
        for (int k = 0; k < 6; k++) begin
            tune_setting_in = k[0] ? OMT_TUNE_ALWAYS : OMT_TUNE_ONCE;
            tune_result_in = {16'($urandom), 16'($urandom), 16'($urandom)};
            tune_fact_in.p_fact = (k == 0) ? FACT_MIN : 10'($urandom_range(1000, 1));
            tune_fact_in.i_fact = FACT_UNIT;
            tune_fact_in.d_fact = FACT_MAX;
            tune_done_in = 1'b1;
            tick(1);
            tune_done_in = 1'b0;
            check("pid_wr", pid_values_wr_out, 1'b1);
            check("tune_wr", tune_setting_wr_out, 1'b1);
            check("tune_off", tune_setting_out, OMT_TUNE_OFF);
            check("pid_val", pid_values_out,
                  {scaled(tune_result_in.p_band, tune_fact_in.p_fact),
                   scaled(tune_result_in.i_time, FACT_UNIT),
                   scaled(tune_result_in.d_time, FACT_MAX)});
            tick(5);
            check("tune_idle", tune_setting_wr_out, 1'b0);
        end
        // Contact not yet settled: manual held, key auto refused
        di_assign_in = OMT_DI_AM;
        host_close = 1'b1;
        key_cmd_in = C_AUTO;
        tick(1);
        key_cmd_in = '0;
        tick(300);
        check("contact_hold", auto_out, 1'b0);
        // Unsettled Remote/Local contact blocks Remote; key request kept apart
        di_assign_in = OMT_DI_RL;
        key_cmd_in = 4'h2;
        tick(1);
        key_cmd_in = '0;
        tick(4);
        check("rl_hold", remote_out, 1'b0);
        check("rl_lamp", far_setpoint_lamp_out, 1'b0);
        exp_rem = 1'b1;
        di_assign_in = OMT_DI_NONE;
        tick(4);
        check_modes();
        end_sim();
    end
endmodule : omt_mode_ctrl_tb
bind omt_mode_ctrl omt_checker omt_checker_i (.*);
`default_nettype wire
